// ### mcu8_instruction_execute.sv
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "mcu8_exec_cfg.svh"
module mcu8_instruction_execute import mcu8_exec_pkg::*; #(
  parameter int PROG_WORDS = 256
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  localparam int PW = $clog2(PROG_WORDS);

  // Refuse program memory sizes the index logic cannot serve
  if (PROG_WORDS < 2 || PROG_WORDS > 32768 || (1 << PW) != PROG_WORDS) begin : g_bad_prog_words
    $error("PROG_WORDS must be a power of two from 2 to 32768");
  end

  // Data and program memories
  logic [7:0] dmem [0:255];
  logic [7:0] prog_mem [0:PROG_WORDS-1];
  // Programmer-visible state
  logic [7:0] acc, ptr_b, ptr_x, stack_pointer, segment;
  logic [6:0] program_counter_upper;
  logic [7:0] program_counter_lower;
  logic carry, half_carry_flag, global_interrupt_enable;
  logic skip_pending, soft_pending;
  // Bus-side registers
  logic [7:0] mem_addr, vec_addr;
  logic [PW-1:0] prog_addr;
  instr_s last_instr;
  ahb_req_s dphase;

  // Next values from the execute logic
  logic [7:0] next_acc, next_b, next_x, next_stk;
  logic [6:0] next_pcu;
  logic [7:0] next_pcl;
  logic next_carry, next_hcarry, next_skip, next_pend;
  // Data-space write port, from the bus or from an instruction
  logic mem_we;
  logic [7:0] mem_wa, mem_wd;

  // Byte read from data space; pointers and stack pointer live in register space
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      `PTR_B_ADDR: rd_byte = ptr_b;
      `PTR_X_ADDR: rd_byte = ptr_x;
      `PTR_STK_ADDR: rd_byte = stack_pointer;
      default: rd_byte = dmem[a];
    endcase
  endfunction : rd_byte

  // Eight-bit add with carry in; returns half carry, carry, sum
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add8 = {lo[4], full};
  endfunction : add8

  // Instruction length in program bytes
  function automatic logic [1:0] instr_len(input instr_s i);
    case (i.op)
      and_immediate_skip_zero_op, load_b_imm_op: instr_len = 2'd2;
      skip_unless_equal_direct_op, load_reg_imm_op: instr_len = 2'd3;
      pointer_low_nibble_test_op, decrement_skip_zero_op, clear_soft_pending_op,
      vector_select_op, no_operation, bit_test_acc_op: instr_len = 2'd1;
      load_mem_imm_op: instr_len = (i.src == src_direct) ? 2'd3 : 2'd2;
      default: begin
        case (i.src)
          src_imm: instr_len = 2'd2;
          src_direct: instr_len = 2'd3;
          default: instr_len = 2'd1;
        endcase
      end
    endcase
  endfunction : instr_len

  // Only aligned whole words inside the low 256-byte window are mapped
  function automatic logic is_mapped(input logic [31:0] a, input logic [2:0] sz);
    is_mapped = (sz == 3'b010) && (a[1:0] == 2'b00) && (a[31:8] == 24'h00_0000);
  endfunction : is_mapped

  // Bus read mux
  function automatic logic [31:0] rd_reg(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `REG_INSTR: v = last_instr;
      `REG_CORE_A: v = {stack_pointer, ptr_x, ptr_b, acc};
      `REG_CORE_B: begin
        v[14:0] = {program_counter_upper, program_counter_lower};
        v[`CB_CARRY_BIT] = carry;
        v[`CB_HCARRY_BIT] = half_carry_flag;
        v[`CB_IRQ_EN_BIT] = global_interrupt_enable;
        v[`CB_SKIP_BIT] = skip_pending;
        v[`CB_PEND_BIT] = soft_pending;
        v[`CB_SEG_LSB +: 8] = segment;
      end
      `REG_CTRL: begin
        v[`CTRL_IRQ_EN_BIT] = global_interrupt_enable;
        v[`CTRL_PEND_SET_BIT] = soft_pending;
        v[`CTRL_SEG_LSB +: 8] = segment;
      end
      `REG_MEM_ADDR: v[7:0] = mem_addr;
      `REG_MEM_DATA: v[7:0] = rd_byte(mem_addr);
      `REG_PROG_ADDR: v[PW-1:0] = prog_addr;
      `REG_PROG_DATA: v[7:0] = prog_mem[prog_addr];
      `REG_VEC_ADDR: v[7:0] = vec_addr;
      default: v = 32'h0000_0000;
    endcase
    rd_reg = v;
  endfunction : rd_reg

  // Bus phase decode and the instruction word seen in a data phase
  wire logic addr_ok = hsel_i && htrans_i[1] && hready_i;
  wire logic wr_dp = dphase.valid && dphase.write;
  wire logic exec_fire = wr_dp && (dphase.addr == `REG_INSTR);
  wire instr_s ins = instr_s'(hwdata_i);

  // Address phase capture; only aligned word accesses are mapped
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dphase <= '0;
    end else if (addr_ok) begin
      dphase.valid <= is_mapped(haddr_i, hsize_i);
      dphase.write <= hwrite_i;
      dphase.addr <= haddr_i[7:0];
    end else begin
      dphase <= '0;
    end
  end

  // Read data registered at the address phase; zero wait states, always OKAY
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= is_mapped(haddr_i, hsize_i) ? rd_reg(haddr_i[7:0]) : 32'h0000_0000;
      end
    end
  end

  // Execute one instruction, or a bus write into data space
  always_comb begin
    logic [7:0] oaddr;
    logic [7:0] opnd;
    logic [7:0] tmp;
    logic [9:0] sum;
    logic ptr_is_b;
    logic do_step;
    oaddr = 8'h00;
    opnd = 8'h00;
    tmp = 8'h00;
    sum = 10'h000;
    ptr_is_b = 1'b0;
    do_step = 1'b0;
    next_acc = acc;
    next_b = ptr_b;
    next_x = ptr_x;
    next_stk = stack_pointer;
    next_pcu = program_counter_upper;
    next_pcl = program_counter_lower;
    next_carry = carry;
    next_hcarry = half_carry_flag;
    next_skip = skip_pending;
    next_pend = soft_pending;
    mem_we = 1'b0;
    mem_wa = 8'h00;
    mem_wd = 8'h00;
    if (wr_dp && dphase.addr == `REG_MEM_DATA) begin
      mem_we = 1'b1;
      mem_wa = mem_addr;
      mem_wd = hwdata_i[7:0];
    end
    if (wr_dp && dphase.addr == `REG_CTRL && hwdata_i[`CTRL_PEND_SET_BIT]) begin
      next_pend = 1'b1;
    end
    if (exec_fire) begin
      case (ins.src)
        src_b_ind: oaddr = ptr_b;
        src_x_ind: oaddr = ptr_x;
        default: oaddr = ins.direct_addr;
      endcase
      ptr_is_b = (ins.src == src_b_ind);
      opnd = (ins.src == src_imm) ? ins.imm : rd_byte(oaddr);
      {next_pcu, next_pcl} = 15'({program_counter_upper, program_counter_lower} + 15'(instr_len(ins)));
      if (skip_pending) begin
        next_skip = 1'b0;
      end else begin
        case (ins.op)
          add_op: next_acc = acc + opnd;
          and_op: next_acc = acc & opnd;
          or_op: next_acc = acc | opnd;
          xor_op: next_acc = acc ^ opnd;
          add_with_carry_op: begin
            sum = add8(acc, opnd, carry);
            {next_hcarry, next_carry, next_acc} = sum;
          end
          subtract_with_carry_op: begin
            sum = add8(acc, ~opnd, carry);
            {next_hcarry, next_carry, next_acc} = sum;
          end
          and_immediate_skip_zero_op: next_skip = ((acc & ins.imm) == 8'h00);
          skip_unless_equal_direct_op: next_skip = (rd_byte(ins.direct_addr) != ins.imm);
          skip_unless_equal_op: next_skip = (acc != opnd);
          skip_unless_different_op: next_skip = (acc == opnd);
          skip_unless_greater_op: next_skip = !(acc > opnd);
          pointer_low_nibble_test_op: next_skip = (ptr_b[3:0] == ins.imm[3:0]);
          decrement_skip_zero_op: begin
            tmp = rd_byte(`REG_SPACE_BASE | ins.direct_addr) - 8'h01;
            mem_we = 1'b1;
            mem_wa = `REG_SPACE_BASE | ins.direct_addr;
            mem_wd = tmp;
            next_skip = (tmp == 8'h00);
          end
          bit_set_op, bit_clear_op: begin
            tmp = opnd;
            tmp[ins.bit_sel] = (ins.op == bit_set_op);
            mem_we = 1'b1;
            mem_wa = oaddr;
            mem_wd = tmp;
          end
          bit_test_op: next_skip = !opnd[ins.bit_sel];
          bit_test_acc_op: next_skip = !acc[ins.bit_sel];
          clear_soft_pending_op: next_pend = 1'b0;
          exchange_op: begin
            mem_we = 1'b1;
            mem_wa = oaddr;
            mem_wd = acc;
            next_acc = opnd;
            do_step = 1'b1;
          end
          load_op: begin
            next_acc = opnd;
            do_step = 1'b1;
          end
          load_b_imm_op: next_b = ins.imm;
          load_mem_imm_op: begin
            mem_we = 1'b1;
            mem_wa = oaddr;
            mem_wd = ins.imm;
            do_step = 1'b1;
          end
          load_reg_imm_op: begin
            mem_we = 1'b1;
            mem_wa = `REG_SPACE_BASE | ins.direct_addr;
            mem_wd = ins.imm;
          end
          vector_select_op: begin
            next_pcu = prog_mem[PW'(vec_addr)][6:0];
            next_pcl = prog_mem[PW'(vec_addr + 8'h01)];
          end
          default: next_acc = acc;
        endcase
      end
    end
    // Writes that land on register-space pointers update the pointer itself
    if (mem_we) begin
      case (mem_wa)
        `PTR_B_ADDR: next_b = mem_wd;
        `PTR_X_ADDR: next_x = mem_wd;
        `PTR_STK_ADDR: next_stk = mem_wd;
        default: next_acc = next_acc;
      endcase
    end
    // Pointer step after the memory access
    if (do_step && ins.src != src_direct && ins.src != src_imm && ins.step != step_none) begin
      if (ptr_is_b) begin
        next_b = (ins.step == step_inc) ? ptr_b + 8'h01 : (ins.step == step_dec) ? ptr_b - 8'h01 : next_b;
      end else begin
        next_x = (ins.step == step_inc) ? ptr_x + 8'h01 : (ins.step == step_dec) ? ptr_x - 8'h01 : next_x;
      end
    end
  end

  // Data memory; pointer addresses are held in their own registers
  always_ff @(posedge clock_i) begin
    if (mem_we && mem_wa != `PTR_B_ADDR && mem_wa != `PTR_X_ADDR && mem_wa != `PTR_STK_ADDR) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  // Program memory loaded over the bus
  always_ff @(posedge clock_i) begin
    if (wr_dp && dphase.addr == `REG_PROG_DATA) begin
      prog_mem[prog_addr] <= hwdata_i[7:0];
    end
  end

  // Accumulator and pointers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      acc <= `RESET_BYTE;
      ptr_b <= `RESET_BYTE;
      ptr_x <= `RESET_BYTE;
      stack_pointer <= `RESET_STACK;
    end else begin
      acc <= next_acc;
      ptr_b <= next_b;
      ptr_x <= next_x;
      stack_pointer <= next_stk;
    end
  end

  // Program counter, upper and lower parts
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      program_counter_upper <= `RESET_COUNT_UPPER;
      program_counter_lower <= `RESET_BYTE;
    end else begin
      program_counter_upper <= next_pcu;
      program_counter_lower <= next_pcl;
    end
  end

  // Status bits and skip state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      skip_pending <= 1'b0;
      soft_pending <= 1'b0;
    end else begin
      carry <= next_carry;
      half_carry_flag <= next_hcarry;
      skip_pending <= next_skip;
      soft_pending <= next_pend;
    end
  end

  // Control register: interrupt enable and segment
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      global_interrupt_enable <= 1'b0;
      segment <= `RESET_BYTE;
    end else if (wr_dp && dphase.addr == `REG_CTRL) begin
      global_interrupt_enable <= hwdata_i[`CTRL_IRQ_EN_BIT];
      segment <= hwdata_i[`CTRL_SEG_LSB +: 8];
    end
  end

  // Bus-side address registers and last instruction
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mem_addr <= `RESET_BYTE;
      vec_addr <= `RESET_BYTE;
      prog_addr <= '0;
      last_instr <= '0;
    end else if (wr_dp) begin
      case (dphase.addr)
        `REG_MEM_ADDR: mem_addr <= hwdata_i[7:0];
        `REG_VEC_ADDR: vec_addr <= hwdata_i[7:0];
        `REG_PROG_ADDR: prog_addr <= hwdata_i[PW-1:0];
        `REG_INSTR: last_instr <= ins;
        default: mem_addr <= mem_addr;
      endcase
    end
  end
endmodule : mcu8_instruction_execute

// ### mcu8_exec_cfg.svh
// Notes on behaviour
// - Add-with-carry: A gets A plus operand plus carry; carry and half carry updated.
// - Subtract-with-carry: A gets A plus inverted operand plus carry; carry and half carry updated.
// - AND-immediate-skip: test A AND immediate, keep A, skip next when zero.
// - Direct byte versus immediate compare: run next only when equal.
// - Equality compare of A with memory, indirect or immediate: run next only on equality.
// - Pointer test: low 4 bits of first pointer versus immediate; run next when different.
// - Decrement register-space byte, write back, skip next when result is zero.
// - Bit set and clear: one memory bit, position 0 to 7, others kept.
// - Bit test: run next only when selected bit of A or memory is one.
// - One instruction clears the software-interrupt pending flag, nothing else.
// - Exchange swaps A with a direct or pointer-addressed memory byte.
// - Exchange and load through a pointer may step it by one afterwards.
// - Load A from memory, pointer or immediate; immediate into pointer, memory, register.
// - Program counter is 15 bits: 7-bit upper and 8-bit lower parts.
// - Stack pointer, accumulator, both pointers and segment register are 8 bits.
// - Register space is data addresses F0 to FF, holding both pointers and stack pointer.
// - Status word holds carry, half carry and global interrupt enable bits.
// - Vector select loads two adjacent program bytes, upper then lower, into the counter.
// - No-operation only advances the program counter.
// - A skipped instruction runs as a no-operation.
`ifndef MCU8_EXEC_CFG_SVH
`define MCU8_EXEC_CFG_SVH
// Bus register byte offsets
`define REG_INSTR 8'h00
`define REG_CORE_A 8'h04
`define REG_CORE_B 8'h08
`define REG_CTRL 8'h0C
`define REG_MEM_ADDR 8'h10
`define REG_MEM_DATA 8'h14
`define REG_PROG_ADDR 8'h18
`define REG_PROG_DATA 8'h1C
`define REG_VEC_ADDR 8'h20
// Register space addresses
`define REG_SPACE_BASE 8'hF0
`define PTR_X_ADDR 8'hFC
`define PTR_STK_ADDR 8'hFD
`define PTR_B_ADDR 8'hFE
// Field positions in CORE_B and CTRL
`define CB_CARRY_BIT 16
`define CB_HCARRY_BIT 17
`define CB_IRQ_EN_BIT 18
`define CB_SKIP_BIT 19
`define CB_PEND_BIT 20
`define CB_SEG_LSB 24
`define CTRL_IRQ_EN_BIT 0
`define CTRL_PEND_SET_BIT 1
`define CTRL_SEG_LSB 8
// Reset values
`define RESET_BYTE 8'h00
`define RESET_COUNT_UPPER 7'h00
`define RESET_STACK 8'h00
`endif

// ### mcu8_exec_pkg.sv
package mcu8_exec_pkg;
  // Instruction operations
  typedef enum logic [4:0] {
    no_operation, add_op, add_with_carry_op, subtract_with_carry_op, and_op, or_op, xor_op,
    and_immediate_skip_zero_op, skip_unless_equal_op, skip_unless_equal_direct_op,
    skip_unless_different_op, skip_unless_greater_op, pointer_low_nibble_test_op,
    decrement_skip_zero_op, bit_set_op, bit_clear_op, bit_test_op, bit_test_acc_op,
    clear_soft_pending_op, exchange_op, load_op, load_b_imm_op, load_mem_imm_op,
    load_reg_imm_op, vector_select_op
  } op_e;
  // Operand source
  typedef enum logic [1:0] {src_b_ind, src_x_ind, src_direct, src_imm} src_e;
  // Pointer step after access
  typedef enum logic [1:0] {step_none, step_inc, step_dec, step_rsvd} step_e;
  // Instruction word as written to the instruction register
  typedef struct packed {
    logic [3:0] pad;
    logic [7:0] direct_addr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    step_e step;
    src_e src;
    op_e op;
  } instr_s;
  // Captured bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_s;
endpackage : mcu8_exec_pkg

// ### mcu8_exec_properties.sv
`timescale 1ns/100ps
`include "mcu8_exec_cfg.svh"
module mcu8_exec_properties import mcu8_exec_pkg::*; (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Address phases that the slave takes
  wire logic take = hsel_i && htrans_i[1] && hready_i;
  wire logic rd_take = take && !hwrite_i;
  wire logic wr_take = take && hwrite_i;
  // Bus steps that lead up to a flag read-back
  sequence s_rd(a);
    rd_take && haddr_i == {24'h00_0000, a} && hsize_i == 3'b010;
  endsequence
  sequence s_wr(a);
    wr_take && haddr_i == {24'h00_0000, a} && hsize_i == 3'b010;
  endsequence
  sequence s_clear_pend;
    s_wr(`REG_INSTR) ##1 hwdata_i[4:0] == clear_soft_pending_op;
  endsequence
  sequence s_set_pend;
    s_wr(`REG_CTRL) ##1 hwdata_i[1];
  endsequence
  a_ready_always: assert property (hreadyout_o) else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp_o) else $error("error response seen");
  a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o)) else $error("read data moved");
  a_unmapped_zero: assert property (rd_take && (haddr_i[31:8] != 24'h00_0000 || haddr_i[7:0] > 8'h20
    || haddr_i[1:0] != 2'b00 || hsize_i != 3'b010) |=> hrdata_o == 32'h0000_0000) else $error("unmapped read");
  a_reset_idle: assert property (disable iff (1'b0) srst_i |=> hrdata_o == 32'h0000_0000 && hreadyout_o)
    else $error("bus outputs not idle in reset");
  a_counter_width: assert property (s_rd(`REG_CORE_B) |=> !hrdata_o[15] && hrdata_o[23:21] == 3'b000)
    else $error("status word has extra bits");
  a_byte_wide: assert property ((s_rd(`REG_MEM_DATA) or s_rd(`REG_PROG_DATA))
    |=> hrdata_o[31:8] == 24'h00_0000) else $error("byte register wider than 8 bits");
  a_ctrl_fields: assert property (s_rd(`REG_CTRL) |=> hrdata_o[31:16] == 16'h0000 && hrdata_o[7:2] == 6'h00)
    else $error("control register reserved bits set");
  a_pend_clear: assert property (s_clear_pend ##1 s_rd(`REG_CORE_B) |=> !hrdata_o[20])
    else $error("soft pending not cleared");
  a_pend_set: assert property (s_set_pend ##1 s_rd(`REG_CTRL) |=> hrdata_o[1]) else $error("soft pending not set");
endmodule : mcu8_exec_properties

// ### mcu8_ahb_master.sv
`timescale 1ns/100ps
module mcu8_ahb_master (
  input wire logic clock_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  // Idle bus at time zero
  initial begin
    hsel_o = 1'b1;
    haddr_o = 32'h0000_0000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0000_0000;
  end
  // Single word transfer; released lines show inverted data so stale values never match
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'b10;
    do @(posedge clock_i); while (hready_i !== 1'b1);
    htrans_o <= 2'b00;
    haddr_o <= ~a;
    hwdata_o <= wd;
    do @(posedge clock_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
    hwdata_o <= ~wd;
  endtask : xfer
endmodule : mcu8_ahb_master

// ### mcu8_instruction_execute_tb.sv
`timescale 1ns/100ps
`include "mcu8_exec_cfg.svh"
module mcu8_instruction_execute_tb import mcu8_exec_pkg::*; ;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  logic c = 1'b0;
  logic hcy = 1'b0;
  op_e alu_ops [6] = '{add_op, add_with_carry_op, subtract_with_carry_op, and_op, or_op, xor_op};
  op_e cond_ops [8] = '{skip_unless_equal_op, skip_unless_equal_direct_op, skip_unless_different_op,
    skip_unless_greater_op, and_immediate_skip_zero_op, pointer_low_nibble_test_op, bit_test_acc_op, bit_test_op};
  // Clock
  always #5 clock_i = ~clock_i;
  mcu8_instruction_execute #(.PROG_WORDS(256)) mcu8_instruction_execute_i (.clock_i(clock_i), .srst_i(srst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp));
  mcu8_ahb_master mcu8_ahb_master_i (.clock_i(clock_i), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    mcu8_ahb_master_i.xfer(1'b1, {24'h00_0000, a}, d, unused);
  endtask : wr
  // Read a register and compare one field of it
  task automatic chkf(input logic [7:0] a, input int lsb, input int w, input logic [31:0] e);
    logic [31:0] d;
    mcu8_ahb_master_i.xfer(1'b0, {24'h00_0000, a}, 32'h0000_0000, d);
    chk((d >> lsb) & ((32'h0000_0001 << w) - 32'h0000_0001), e);
  endtask : chkf
  task automatic wrm(input logic [7:0] a, input logic [7:0] v);
    wr(`REG_MEM_ADDR, 32'(a));
    wr(`REG_MEM_DATA, 32'(v));
  endtask : wrm
  task automatic chkm(input logic [7:0] a, input logic [7:0] e);
    wr(`REG_MEM_ADDR, 32'(a));
    chkf(`REG_MEM_DATA, 0, 8, 32'(e));
  endtask : chkm
  task automatic exe(input op_e op, input src_e src, input logic [7:0] imm, input logic [7:0] da = 8'h00,
    input logic [2:0] b = 3'h0, input step_e st = step_none);
    instr_s i;
    i = '{pad: 4'h0, direct_addr: da, imm: imm, bit_sel: b, step: st, src: src, op: op};
    wr(`REG_INSTR, i);
  endtask : exe
  // Expected flags and accumulator, as {carry, half carry, value}
  function automatic logic [9:0] alu(op_e op, logic [7:0] a, logic [7:0] b, logic ci, logic hi);
    logic [7:0] m;
    logic [8:0] s;
    logic [4:0] h;
    logic cin;
    m = (op == subtract_with_carry_op) ? ~b : b;
    cin = (op == add_op) ? 1'b0 : ci;
    s = {1'b0, a} + {1'b0, m} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(cin);
    case (op)
      add_op: alu = {ci, hi, s[7:0]};
      and_op: alu = {ci, hi, a & b};
      or_op: alu = {ci, hi, a | b};
      xor_op: alu = {ci, hi, a ^ b};
      default: alu = {s[8], h[4], s[7:0]};
    endcase
  endfunction : alu
  // Whether a conditional skips its follower
  function automatic logic skips(op_e op, logic [7:0] a, logic [7:0] b, logic [2:0] k);
    case (op)
      skip_unless_equal_op, skip_unless_equal_direct_op: skips = (a != b);
      skip_unless_different_op: skips = (a == b);
      skip_unless_greater_op: skips = !(a > b);
      and_immediate_skip_zero_op: skips = ((a & b) == 8'h00);
      pointer_low_nibble_test_op: skips = (a[3:0] == b[3:0]);
      default: skips = !a[k];
    endcase
  endfunction : skips
  // Cut a hang short
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, cycles, 0);
      close_out();
    end
  end
  // Main sequence
  initial begin : main
    logic [31:0] d;
    logic [7:0] a, b, m;
    logic [2:0] k;
    logic [9:0] r;
    op_e op;
    d = $urandom(32'h8e915a92);
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    chkf(`REG_CORE_A, 0, 32, 32'h0000_0000);
    chkf(`REG_CORE_B, 0, 32, 32'h0000_0000);
    chkf(`REG_CTRL, 0, 32, 32'h0000_0000);
    wr(8'h24, 32'hffff_ffff);
    chkf(8'h24, 0, 32, 32'h0000_0000);
    chkf(`REG_CORE_A, 0, 32, 32'h0000_0000);
    $display("reset and map test done");
    for (int i = 0; i < 24; i++) begin
      op = alu_ops[$urandom_range(5)];
      a = 8'($urandom);
      b = (i < 3) ? 8'hff : 8'($urandom);
      exe(load_op, src_imm, a);
      exe(op, src_imm, b);
      r = alu(op, a, b, c, hcy);
      {c, hcy} = r[9:8];
      chkf(`REG_CORE_A, 0, 8, 32'(r[7:0]));
      chkf(`REG_CORE_B, 16, 2, 32'({hcy, c}));
    end
    $display("arithmetic test done");
    for (int i = 0; i < 32; i++) begin
      op = cond_ops[i % 8];
      a = 8'($urandom);
      b = $urandom_range(1) ? a : 8'($urandom);
      b = (op == pointer_low_nibble_test_op) ? (b & 8'h0f) : b;
      k = 3'($urandom);
      exe(load_op, src_imm, a);
      exe(load_b_imm_op, src_imm, a);
      wrm(8'h40, a);
      exe(op, (op == skip_unless_equal_direct_op || op == bit_test_op) ? src_direct : src_imm, b, 8'h40, k);
      exe(load_op, src_imm, 8'h5a);
      chkf(`REG_CORE_A, 0, 8, 32'(skips(op, a, b, k) ? a : 8'h5a));
      chkf(`REG_CORE_B, 19, 1, 32'h0000_0000);
    end
    $display("conditional test done");
    for (int i = 0; i < 8; i++) begin
      m = 8'($urandom);
      wrm(8'h40, m);
      exe(bit_set_op, src_direct, 8'h00, 8'h40, 3'(i));
      chkm(8'h40, m | (8'h01 << i));
      exe(bit_clear_op, src_direct, 8'h00, 8'h40, 3'(i));
      chkm(8'h40, m & ~(8'h01 << i));
    end
    $display("bit test done");
    a = 8'($urandom);
    m = 8'($urandom);
    b = 8'($urandom);
    exe(load_op, src_imm, a);
    wrm(8'h40, m);
    wrm(8'h41, b);
    exe(exchange_op, src_direct, 8'h00, 8'h40);
    chkf(`REG_CORE_A, 0, 8, 32'(m));
    chkm(8'h40, a);
    exe(load_b_imm_op, src_imm, 8'h40);
    exe(exchange_op, src_b_ind, 8'h00, 8'h00, 3'h0, step_inc);
    chkf(`REG_CORE_A, 0, 8, 32'(a));
    chkf(`REG_CORE_A, 8, 8, 32'h0000_0041);
    exe(load_op, src_b_ind, 8'h00, 8'h00, 3'h0, step_dec);
    chkf(`REG_CORE_A, 0, 16, {16'h0000, 8'h40, b});
    exe(load_reg_imm_op, src_direct, 8'h41, 8'h0c);
    exe(load_mem_imm_op, src_x_ind, 8'h77, 8'h00, 3'h0, step_inc);
    chkm(8'h41, 8'h77);
    chkf(`REG_CORE_A, 16, 8, 32'h0000_0042);
    exe(load_reg_imm_op, src_direct, 8'h33, 8'h06);
    chkm(8'hf6, 8'h33);
    exe(load_mem_imm_op, src_direct, 8'h66, 8'h42);
    chkm(8'h42, 8'h66);
    $display("exchange and load test done");
    wrm(8'hf5, 8'h02);
    exe(decrement_skip_zero_op, src_direct, 8'h00, 8'h05);
    exe(load_op, src_imm, 8'h11);
    exe(decrement_skip_zero_op, src_direct, 8'h00, 8'h05);
    exe(load_op, src_imm, 8'h22);
    chkf(`REG_CORE_A, 0, 8, 32'h0000_0011);
    chkm(8'hf5, 8'h00);
    wr(`REG_CTRL, 32'h0000_0003);
    chkf(`REG_CTRL, 0, 2, 32'h0000_0003);
    exe(clear_soft_pending_op, src_b_ind, 8'h00);
    chkf(`REG_CORE_B, 18, 3, 32'h0000_0001);
    chkf(`REG_CORE_A, 0, 8, 32'h0000_0011);
    $display("decrement and pending test done");
    wr(`REG_PROG_ADDR, 32'h0000_0010);
    wr(`REG_PROG_DATA, 32'(a));
    wr(`REG_PROG_ADDR, 32'h0000_0011);
    wr(`REG_PROG_DATA, 32'(m));
    wr(`REG_VEC_ADDR, 32'h0000_0010);
    exe(vector_select_op, src_b_ind, 8'h00);
    chkf(`REG_CORE_B, 0, 15, 32'({a[6:0], m}));
    exe(no_operation, src_b_ind, 8'h00);
    chkf(`REG_CORE_B, 0, 15, 32'(15'({a[6:0], m}) + 15'h0001));
    chkf(`REG_CORE_A, 0, 8, 32'h0000_0011);
    $display("vector and no-operation test done");
    close_out();
  end
endmodule : mcu8_instruction_execute_tb
bind mcu8_instruction_execute mcu8_exec_properties mcu8_exec_properties_i (.clock_i(clock_i), .srst_i(srst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
